// File: rtl/bsfu_pkg.sv
// Package: register map, field positions, states and carriers of the source fetch unit
package bsfu_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFF_LINE_STRIDE = 8'h00;
  localparam logic [7:0] OFF_SHARED_BG   = 8'h04;
  localparam logic [7:0] OFF_SHARED_FG   = 8'h08;
  localparam logic [7:0] OFF_MONO_CTL    = 8'h0C;
  localparam logic [7:0] OFF_BLIT_CTL    = 8'h10;
  localparam logic [7:0] OFF_SRC_ADDR    = 8'h18;
  localparam logic [7:0] OFF_SRC_BG      = 8'h24;
  localparam logic [7:0] OFF_SRC_FG      = 8'h28;
  localparam logic [7:0] OFF_GEOM        = 8'h30;
  localparam logic [7:0] OFF_CMD         = 8'h34;

  // ==========================================================================
  // Field positions
  localparam int BLIT_DEPTH_LSB   = 0;
  localparam int BLIT_SRC_HOST    = 10;
  localparam int BLIT_SRC_MONO    = 12;
  localparam int MONO_LEFT_LSB    = 0;
  localparam int MONO_RIGHT_LSB   = 8;
  localparam int MONO_FIRST_LSB   = 16;
  localparam int MONO_ALIGN_LSB   = 24;
  localparam int MONO_OWN_COLOR   = 27;
  localparam int GEOM_WIDTH_LSB   = 0;
  localparam int GEOM_LINES_LSB   = 16;
  localparam int CMD_START        = 0;
  localparam int STAT_BUSY        = 0;
  localparam int STAT_DONE        = 1;

  // ==========================================================================
  // Values after reset and fixed sizes
  localparam logic [31:0] RST_REG      = 32'h0000_0000;
  localparam logic [6:0]  QWORD_BITS   = 7'h40;
  localparam logic [15:0] WIN_SPAN_LOG = 16'h0010;

  // ==========================================================================
  // Line alignment codes
  localparam logic [2:0] ALIGN_QWORD = 3'h0;
  localparam logic [2:0] ALIGN_DWORD = 3'h1;
  localparam logic [2:0] ALIGN_WORD  = 3'h2;
  localparam logic [2:0] ALIGN_BYTE  = 3'h3;
  localparam logic [2:0] ALIGN_NONE  = 3'h4;

  // ==========================================================================
  // States and carriers
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LINE,
    ST_SKIP,
    ST_FETCH,
    ST_EMIT,
    ST_TAIL,
    ST_NEXT
  } bsfu_state_t;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [31:0] addr;
    logic [63:0] wdata;
  } bsfu_win_req_t;

endpackage

// File: rtl/bsfu_color_expand.sv
// Colour expansion of one source bit into one colour byte
`timescale 1ns/1ps
`default_nettype none
module bsfu_color_expand (
  input  wire logic        mono,
  input  wire logic        bit_val,
  input  wire logic        own_sel,
  input  wire logic [7:0]  raw_byte,
  input  wire logic [23:0] shr_fg,
  input  wire logic [23:0] shr_bg,
  input  wire logic [23:0] own_fg,
  input  wire logic [23:0] own_bg,
  input  wire logic [1:0]  byte_idx,
  output logic      [7:0]  byte_out
);
  logic [23:0] fg;
  logic [23:0] bg;
  logic [23:0] col;

  always_comb begin
    fg       = own_sel ? own_fg : shr_fg;
    bg       = own_sel ? own_bg : shr_bg;
    col      = bit_val ? fg : bg;
    // Colour source passes at engine depth untouched
    byte_out = mono ? col[{byte_idx, 3'b000} +: 8] : raw_byte;
  end
endmodule
`default_nettype wire

// File: rtl/bsfu_source_fetch.sv
// Source fetch and unpack front end of the block transfer engine
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Bit 10 picks frame buffer or host
// - Source address is frame buffer byte offset
// - Host source: low three bits skip bytes
// - Any write in 64KB window is data
// - Window has no storage; reads give zero
// - Window writes used in arrival order
// - Next line start advances by stride
// - Block is start, length, stride, count
// - Bit 12 picks colour or monochrome source
// - Colour source uses engine colour depth
// - Bit one gives foreground, zero background
// - Mono bit becomes one to three bytes
// - Bit 27 picks shared or own colours
// - Bits 26-24 give mono line alignment
// - Bits 21-16 discard first block bits
// - Bits 5-0 clip each line left
// - Bits 13-8 clip each line right
module bsfu_source_fetch #(
  parameter int          FB_AW    = 24,
  parameter logic [31:0] WIN_BASE = 32'h000A_0000
) (
  input  wire logic                   clock,
  input  wire logic                   srst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire bsfu_pkg::bsfu_win_req_t win_req,
  output logic                        win_ready,
  output logic      [63:0]            win_rdata,
  output logic                        fb_req,
  output logic      [FB_AW-1:0]       fb_addr,
  input  wire logic                   fb_ack,
  input  wire logic [63:0]            fb_rdata,
  output logic                        out_valid,
  output logic      [7:0]             out_data,
  output logic                        out_last,
  input  wire logic                   out_ready,
  output logic                        busy,
  output logic                        done
);
  // ==========================================================================
  // Elaboration checks
  if (FB_AW < 8 || FB_AW > 32) begin : g_bad_aw
    $error("FB_AW must lie in 8..32");
  end
  if (WIN_BASE[15:0] != 16'h0000) begin : g_bad_base
    $error("WIN_BASE must sit on a 64KB boundary");
  end

  // ==========================================================================
  // Registers and state
  logic [31:0] blit_ctl_q, mono_ctl_q, src_addr_q, stride_q, geom_q;
  logic [31:0] shr_fg_q, shr_bg_q, own_fg_q, own_bg_q;
  bsfu_pkg::bsfu_state_t state_q, ret_q;
  logic [FB_AW-1:0] line_addr_q, qw_addr_q;
  logic [63:0] qword_q;
  logic        have_q, first_q, done_q;
  logic [6:0]  ptr_q;
  logic [7:0]  skip_q;
  logic [15:0] cnt_q, lines_q;
  logic [1:0]  sub_q;
  logic        out_valid_q, out_last_q;
  logic [7:0]  out_data_q;

  // ==========================================================================
  // Decoded fields
  logic        host_sel, mono_sel, own_sel;
  logic [1:0]  depth_m1;
  logic [2:0]  align;
  logic [5:0]  left_clip, right_clip, first_skip;
  logic [15:0] width, lines, mono_cnt;
  logic [6:0]  clip_sum;

  assign host_sel   = blit_ctl_q[bsfu_pkg::BLIT_SRC_HOST];
  assign mono_sel   = blit_ctl_q[bsfu_pkg::BLIT_SRC_MONO];
  assign own_sel    = mono_ctl_q[bsfu_pkg::MONO_OWN_COLOR];
  assign depth_m1   = (blit_ctl_q[bsfu_pkg::BLIT_DEPTH_LSB +: 2] == 2'h3) ? 2'h2
                    : blit_ctl_q[bsfu_pkg::BLIT_DEPTH_LSB +: 2];
  assign align      = mono_ctl_q[bsfu_pkg::MONO_ALIGN_LSB +: 3];
  assign left_clip  = mono_ctl_q[bsfu_pkg::MONO_LEFT_LSB +: 6];
  assign right_clip = mono_ctl_q[bsfu_pkg::MONO_RIGHT_LSB +: 6];
  assign first_skip = mono_ctl_q[bsfu_pkg::MONO_FIRST_LSB +: 6];
  assign width      = geom_q[bsfu_pkg::GEOM_WIDTH_LSB +: 16];
  assign lines      = geom_q[bsfu_pkg::GEOM_LINES_LSB +: 16];
  assign clip_sum   = {1'b0, left_clip} + {1'b0, right_clip};
  assign mono_cnt   = ({9'h000, clip_sum} >= width) ? 16'h0000
                    : width - {9'h000, clip_sum};

  // ==========================================================================
  // Bit offset of a frame buffer mono line start under the declared alignment
  function automatic logic [6:0] line_off(input logic [2:0] a, input logic [2:0] al);
    case (al)
      bsfu_pkg::ALIGN_QWORD: line_off = 7'h00;
      bsfu_pkg::ALIGN_DWORD: line_off = {1'b0, a[2], 5'h00};
      bsfu_pkg::ALIGN_WORD:  line_off = {1'b0, a[2:1], 4'h0};
      default:               line_off = {1'b0, a, 3'h0};
    endcase
  endfunction

  // Host stream: next line begins on the declared boundary
  function automatic logic [6:0] round_up(input logic [6:0] p, input logic [2:0] al);
    case (al)
      bsfu_pkg::ALIGN_QWORD: round_up = (p[5:0] != 6'h00) ? bsfu_pkg::QWORD_BITS : p;
      bsfu_pkg::ALIGN_DWORD: round_up = (p[4:0] != 5'h00) ? {p[6:5] + 2'h1, 5'h00} : p;
      bsfu_pkg::ALIGN_WORD:  round_up = (p[3:0] != 4'h0) ? {p[6:4] + 3'h1, 4'h0} : p;
      bsfu_pkg::ALIGN_BYTE:  round_up = (p[2:0] != 3'h0) ? {p[6:3] + 4'h1, 3'h0} : p;
      default:               round_up = p;
    endcase
  endfunction

  // ==========================================================================
  // Host window and frame buffer handshakes
  logic in_window, host_take, fb_take, got, need, slot, emit_fire, unit_end;
  logic start_req, finish, apb_wr;
  logic [6:0] unit_bits;
  logic [7:0] exp_byte;

  assign in_window = win_req.sel
                   && (win_req.addr[31:16] == WIN_BASE[31:16]);
  // Offset inside the window plays no part in ordering
  assign host_take = in_window && win_req.write && host_sel
                   && (state_q == bsfu_pkg::ST_FETCH);
  // Reads finish at once; writes stall until the engine wants a quadword
  assign win_ready = in_window && (!win_req.write || host_take);
  assign win_rdata = 64'h0000_0000_0000_0000;
  assign fb_req    = (state_q == bsfu_pkg::ST_FETCH) && !host_sel;
  assign fb_addr   = qw_addr_q;
  assign fb_take   = fb_req && fb_ack;
  assign got       = host_sel ? host_take : fb_take;
  assign need      = !have_q || ptr_q[6];
  assign slot      = !out_valid_q || out_ready;
  assign unit_bits = mono_sel ? 7'h01 : 7'h08;
  assign unit_end  = !mono_sel || (sub_q == depth_m1);
  assign emit_fire = (state_q == bsfu_pkg::ST_EMIT) && (cnt_q != 16'h0000)
                   && !need && slot;
  assign apb_wr    = psel && penable && pwrite;
  assign start_req = apb_wr && (paddr == bsfu_pkg::OFF_CMD)
                   && pwdata[bsfu_pkg::CMD_START] && (state_q == bsfu_pkg::ST_IDLE);
  assign finish    = ((state_q == bsfu_pkg::ST_NEXT) && (lines_q <= 16'h0001))
                   || (start_req && (lines == 16'h0000));

  bsfu_color_expand u_expand (
    .mono     (mono_sel),
    .bit_val  (qword_q[ptr_q[5:0]]),
    .own_sel  (own_sel),
    .raw_byte (qword_q[{ptr_q[5:3], 3'b000} +: 8]),
    .shr_fg   (shr_fg_q[23:0]),
    .shr_bg   (shr_bg_q[23:0]),
    .own_fg   (own_fg_q[23:0]),
    .own_bg   (own_bg_q[23:0]),
    .byte_idx (sub_q),
    .byte_out (exp_byte)
  );

  // ==========================================================================
  // Fetch and unpack sequencer
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q     <= bsfu_pkg::ST_IDLE;
      ret_q       <= bsfu_pkg::ST_IDLE;
      line_addr_q <= '0;
      qw_addr_q   <= '0;
      qword_q     <= 64'h0000_0000_0000_0000;
      have_q      <= 1'b0;
      first_q     <= 1'b0;
      ptr_q       <= 7'h00;
      skip_q      <= 8'h00;
      cnt_q       <= 16'h0000;
      lines_q     <= 16'h0000;
      sub_q       <= 2'h0;
    end else begin
      case (state_q)
        bsfu_pkg::ST_IDLE: begin
          if (start_req && (lines != 16'h0000)) begin
            line_addr_q <= src_addr_q[FB_AW-1:0];
            lines_q     <= lines;
            first_q     <= 1'b1;
            have_q      <= 1'b0;
            ptr_q       <= 7'h00;
            state_q     <= bsfu_pkg::ST_LINE;
          end
        end
        bsfu_pkg::ST_LINE: begin
          qw_addr_q <= {line_addr_q[FB_AW-1:3], 3'h0};
          if (!host_sel) begin
            have_q <= 1'b0;
            ptr_q  <= mono_sel ? line_off(line_addr_q[2:0], align)
                    : {1'b0, line_addr_q[2:0], 3'h0};
          end else if (first_q) begin
            have_q <= 1'b0;
            ptr_q  <= {1'b0, src_addr_q[2:0], 3'h0};
          end
          skip_q  <= !mono_sel ? 8'h00
                   : {2'h0, left_clip} + (first_q ? {2'h0, first_skip} : 8'h00);
          cnt_q   <= mono_sel ? mono_cnt : width;
          sub_q   <= 2'h0;
          state_q <= bsfu_pkg::ST_SKIP;
        end
        bsfu_pkg::ST_SKIP, bsfu_pkg::ST_TAIL: begin
          if (skip_q == 8'h00) begin
            if (state_q == bsfu_pkg::ST_TAIL) begin
              ptr_q   <= round_up(ptr_q, align);
              state_q <= bsfu_pkg::ST_NEXT;
            end else begin
              state_q <= bsfu_pkg::ST_EMIT;
            end
          end else if (need) begin
            ret_q   <= state_q;
            state_q <= bsfu_pkg::ST_FETCH;
          end else begin
            ptr_q  <= ptr_q + 7'h01;
            skip_q <= skip_q - 8'h01;
          end
        end
        bsfu_pkg::ST_FETCH: begin
          if (got) begin
            qword_q   <= host_sel ? win_req.wdata : fb_rdata;
            have_q    <= 1'b1;
            qw_addr_q <= qw_addr_q + FB_AW'(8);
            if (ptr_q[6]) begin
              ptr_q <= 7'h00;
            end
            state_q <= ret_q;
          end
        end
        bsfu_pkg::ST_EMIT: begin
          if (cnt_q == 16'h0000) begin
            // Host lines run on in one stream, so the right clip is eaten here
            skip_q  <= {2'h0, right_clip};
            state_q <= (host_sel && mono_sel) ? bsfu_pkg::ST_TAIL : bsfu_pkg::ST_NEXT;
          end else if (need) begin
            ret_q   <= bsfu_pkg::ST_EMIT;
            state_q <= bsfu_pkg::ST_FETCH;
          end else if (slot) begin
            if (unit_end) begin
              ptr_q <= ptr_q + unit_bits;
              cnt_q <= cnt_q - 16'h0001;
              sub_q <= 2'h0;
            end else begin
              sub_q <= sub_q + 2'h1;
            end
          end
        end
        bsfu_pkg::ST_NEXT: begin
          lines_q     <= lines_q - 16'h0001;
          first_q     <= 1'b0;
          line_addr_q <= line_addr_q + FB_AW'(stride_q[15:0]);
          state_q     <= (lines_q <= 16'h0001) ? bsfu_pkg::ST_IDLE : bsfu_pkg::ST_LINE;
        end
        default: state_q <= bsfu_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Output byte stage
  always_ff @(posedge clock) begin
    if (srst) begin
      out_valid_q <= 1'b0;
      out_data_q  <= 8'h00;
      out_last_q  <= 1'b0;
    end else if (emit_fire) begin
      out_valid_q <= 1'b1;
      out_data_q  <= exp_byte;
      out_last_q  <= (cnt_q == 16'h0001) && unit_end;
    end else if (out_ready) begin
      out_valid_q <= 1'b0;
    end
  end

  assign out_valid = out_valid_q;
  assign out_data  = out_data_q;
  assign out_last  = out_last_q;

  // ==========================================================================
  // Completion flag: finishing beats a clear in the same cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      done_q <= 1'b0;
    end else if (finish) begin
      done_q <= 1'b1;
    end else if (start_req) begin
      done_q <= 1'b0;
    end
  end

  assign busy = (state_q != bsfu_pkg::ST_IDLE);
  assign done = done_q;

  // ==========================================================================
  // APB register file, zero wait states
  always_ff @(posedge clock) begin
    if (srst) begin
      blit_ctl_q <= bsfu_pkg::RST_REG;
      mono_ctl_q <= bsfu_pkg::RST_REG;
      src_addr_q <= bsfu_pkg::RST_REG;
      stride_q   <= bsfu_pkg::RST_REG;
      geom_q     <= bsfu_pkg::RST_REG;
      shr_fg_q   <= bsfu_pkg::RST_REG;
      shr_bg_q   <= bsfu_pkg::RST_REG;
      own_fg_q   <= bsfu_pkg::RST_REG;
      own_bg_q   <= bsfu_pkg::RST_REG;
    end else if (apb_wr) begin
      if (paddr == bsfu_pkg::OFF_LINE_STRIDE) begin
        stride_q <= {16'h0000, pwdata[15:0]};
      end else if (paddr == bsfu_pkg::OFF_SHARED_BG) begin
        shr_bg_q <= {8'h00, pwdata[23:0]};
      end else if (paddr == bsfu_pkg::OFF_SHARED_FG) begin
        shr_fg_q <= {8'h00, pwdata[23:0]};
      end else if (paddr == bsfu_pkg::OFF_MONO_CTL) begin
        mono_ctl_q <= pwdata & 32'h0F3F_3F3F;
      end else if (paddr == bsfu_pkg::OFF_BLIT_CTL) begin
        blit_ctl_q <= pwdata & 32'h0000_1403;
      end else if (paddr == bsfu_pkg::OFF_SRC_ADDR) begin
        src_addr_q <= pwdata & (32'hFFFF_FFFF >> (32 - FB_AW));
      end else if (paddr == bsfu_pkg::OFF_SRC_BG) begin
        own_bg_q <= {8'h00, pwdata[23:0]};
      end else if (paddr == bsfu_pkg::OFF_SRC_FG) begin
        own_fg_q <= {8'h00, pwdata[23:0]};
      end else if (paddr == bsfu_pkg::OFF_GEOM) begin
        geom_q <= pwdata;
      end
    end
  end

  logic mapped;
  always_comb begin
    mapped = 1'b1;
    prdata = 32'h0000_0000;
    if (paddr == bsfu_pkg::OFF_LINE_STRIDE) begin
      prdata = stride_q;
    end else if (paddr == bsfu_pkg::OFF_SHARED_BG) begin
      prdata = shr_bg_q;
    end else if (paddr == bsfu_pkg::OFF_SHARED_FG) begin
      prdata = shr_fg_q;
    end else if (paddr == bsfu_pkg::OFF_MONO_CTL) begin
      prdata = mono_ctl_q;
    end else if (paddr == bsfu_pkg::OFF_BLIT_CTL) begin
      prdata = blit_ctl_q;
    end else if (paddr == bsfu_pkg::OFF_SRC_ADDR) begin
      prdata = src_addr_q;
    end else if (paddr == bsfu_pkg::OFF_SRC_BG) begin
      prdata = own_bg_q;
    end else if (paddr == bsfu_pkg::OFF_SRC_FG) begin
      prdata = own_fg_q;
    end else if (paddr == bsfu_pkg::OFF_GEOM) begin
      prdata = geom_q;
    end else if (paddr == bsfu_pkg::OFF_CMD) begin
      prdata[bsfu_pkg::STAT_BUSY] = busy;
      prdata[bsfu_pkg::STAT_DONE] = done_q;
    end else begin
      mapped = 1'b0;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  chk_fb_not_host: assert property (fb_req |-> !host_sel)
    else $error("frame buffer fetch while host source selected");
  chk_first_line_addr: assert property (
    (state_q == bsfu_pkg::ST_LINE) && first_q |-> line_addr_q == src_addr_q[FB_AW-1:0])
    else $error("first line does not start at source address");
  chk_host_byte_skip: assert property (
    (state_q == bsfu_pkg::ST_LINE) && first_q && host_sel
    |=> ptr_q == {1'b0, $past(src_addr_q[2:0]), 3'h0})
    else $error("host first quadword byte skip wrong");
  chk_window_write: assert property (
    win_req.sel && win_req.write && (win_req.addr[31:16] == WIN_BASE[31:16]) && host_sel
    && (state_q == bsfu_pkg::ST_FETCH)
    |-> win_ready ##1 (have_q && (state_q != bsfu_pkg::ST_FETCH)))
    else $error("window write not taken once while fetching");
  chk_window_read: assert property (
    in_window && !win_req.write |-> win_ready && (win_rdata == 64'h0000_0000_0000_0000))
    else $error("window read not answered with zero");
  chk_arrival_order: assert property (
    host_take |=> have_q && (qword_q == $past(win_req.wdata)))
    else $error("host word not loaded in order");
  chk_stride_step: assert property (
    state_q == bsfu_pkg::ST_NEXT
    |=> line_addr_q == $past(line_addr_q) + FB_AW'($past(stride_q[15:0])))
    else $error("line start not advanced by stride");
  chk_mono_count: assert property (
    (state_q == bsfu_pkg::ST_LINE) && mono_sel |=> cnt_q == $past(mono_cnt))
    else $error("mono line count ignores clipping");
  chk_mono_fg: assert property (
    emit_fire && mono_sel && qword_q[ptr_q[5:0]] && (sub_q == 2'h0)
    |=> out_data_q == $past(own_sel ? own_fg_q[7:0] : shr_fg_q[7:0]))
    else $error("set bit did not expand to foreground");
  chk_block_end: assert property (
    (state_q == bsfu_pkg::ST_NEXT) && (lines_q == 16'h0001)
    |=> (state_q == bsfu_pkg::ST_IDLE) && done_q)
    else $error("block did not end after last line");
endmodule
`default_nettype wire

// File: dv/bsfu_host_model.sv
// Host side model: writes and reads the source data window
`timescale 1ns/1ps
`default_nettype none
module bsfu_host_model (
  input  wire logic                    clock,
  input  wire logic                    win_ready,
  input  wire logic [63:0]             win_rdata,
  output var  bsfu_pkg::bsfu_win_req_t win_req
);
  initial win_req = '0;
  // Request held until taken; released data inverted so stale values never match
  task automatic put(input logic [31:0] a, input logic w, input logic [63:0] d,
                     output logic [63:0] rd);
    int i;
    win_req <= '{1'b1, w, {a[31:3], 3'h0}, d};
    for (i = 0; i < 300; i++) begin
      @(posedge clock);
      if (win_ready === 1'b1) break;
    end
    // Unknown on timeout so any compare of it fails
    rd = (win_ready === 1'b1) ? win_rdata : 64'hX;
    win_req <= '{1'b0, 1'b0, 32'h0, ~d};
  endtask
endmodule
`default_nettype wire

// File: dv/bsfu_source_fetch_tb.sv
// Self-checking bench of the source fetch unit
`timescale 1ns/1ps
`default_nettype none
module bsfu_source_fetch_tb;
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} bsfu_row_t;
  logic clock, srst, psel, penable, pwrite, pready, pslverr, win_ready, fb_req, err;
  logic fb_ack = 1'b0, out_ready = 1'b0;
  logic out_valid, out_last, busy, done;
  logic [7:0] paddr, out_data;
  logic [31:0] pwdata, prdata, r;
  logic [63:0] win_rdata, r64;
  logic [63:0] fb_rdata = 64'h0000_0000_0000_0000;
  logic [23:0] fb_addr;
  bsfu_pkg::bsfu_win_req_t win_req;
  int failures = 0, n_tests = 0, nl = 0;
  logic [7:0] got[$], exp[$];
  logic [23:0] fa[$];
  bsfu_row_t rows[6] = '{'{8'h00, 32'h1234ABCD, 32'h0000ABCD}, '{8'h04, 32'hFFFFFFFF, 32'h00FFFFFF},
    '{8'h0C, 32'hFFFFFFFF, 32'h0F3F3F3F}, '{8'h10, 32'hFFFFFFFF, 32'h00001403},
    '{8'h18, 32'hFFFFFFFF, 32'h00FFFFFF}, '{8'h3C, 32'hFFFFFFFF, 32'h00000000}};
  bsfu_source_fetch i_dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .win_req(win_req), .win_ready(win_ready), .win_rdata(win_rdata),
    .fb_req(fb_req), .fb_addr(fb_addr), .fb_ack(fb_ack), .fb_rdata(fb_rdata),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last), .out_ready(out_ready),
    .busy(busy), .done(done));
  bsfu_host_model i_host (.clock(clock), .win_ready(win_ready), .win_rdata(win_rdata),
    .win_req(win_req));
  initial begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  // ==========================================================
  // Frame buffer answers one cycle late; byte k carries address+k
  always @(posedge clock) begin
    fb_ack <= fb_req && !fb_ack && !srst;
    for (int k = 0; k < 8; k++) fb_rdata[8*k+:8] <= fb_req ? 8'(fb_addr + k) : ~fb_rdata[8*k+:8];
    if (fb_req && fb_ack) fa.push_back(fb_addr);
    if (out_valid && out_ready) got.push_back(out_data);
    if (out_valid && out_ready && out_last) nl <= nl + 1;
    out_ready <= ~out_ready; // Sink stalls every other cycle
  end
  task automatic cmp(input string n, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (i == 50) failures++;
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    // One idle edge so the next call never drives psel twice in a step
    @(posedge clock);
  endtask
  task automatic go(input logic host, input logic [63:0] d, input int nl_e);
    int n0;
    got.delete(); fa.delete();
    n0 = nl;
    apb(1, bsfu_pkg::OFF_CMD, 32'h1);
    if (host) i_host.put(32'h000A_1239, 1'b1, d, r64);
    for (int i = 0; i < 500 && busy !== 1'b0; i++) @(posedge clock);
    if (busy !== 1'b0) failures++;
    repeat (2) @(posedge clock);
    cmp("done", 1, done);
    cmp("lines", nl_e, nl - n0);
    cmp("count", exp.size(), got.size());
    foreach (exp[i]) cmp("byte", exp[i], got[i]);
  endtask
  task automatic end_sim;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    end_sim();
  end
  initial begin
    logic [23:0] c;
    {srst, psel, penable, pwrite, paddr, pwdata} = '0;
    srst = 1;
    repeat (4) @(posedge clock);
    srst <= 0;
    foreach (rows[i]) begin
      apb(0, rows[i].a, 32'h0);
      cmp("reset", 0, r);
      apb(1, rows[i].a, rows[i].w);
      cmp("slverr", rows[i].a == 8'h3C, err);
      apb(0, rows[i].a, 32'h0);
      cmp("reg", rows[i].e, r);
    end
    $display("test registers done");
    i_host.put(32'h000A_0010, 1'b0, 64'h0, r64);
    cmp("window read", 0, r64);
    // ==========================================================
    // Colour from frame buffer: two lines, stride 0x104, start byte 3
    apb(1, bsfu_pkg::OFF_BLIT_CTL, 32'h0);
    apb(1, bsfu_pkg::OFF_SRC_ADDR, 32'h13);
    apb(1, bsfu_pkg::OFF_LINE_STRIDE, 32'h104);
    apb(1, bsfu_pkg::OFF_GEOM, 32'h0002_0002);
    exp = '{8'h13, 8'h14, 8'h17, 8'h18};
    go(0, 64'h0, 2);
    cmp("fetches", 3, fa.size());
    cmp("line0 addr", 24'h10, fa[0]);
    cmp("line1 addr", 24'h110, fa[1]);
    cmp("line1 next", 24'h118, fa[2]);
    // Contiguous source: stride equals the two-byte line length
    apb(1, bsfu_pkg::OFF_LINE_STRIDE, 32'h2);
    exp = '{8'h13, 8'h14, 8'h15, 8'h16};
    go(0, 64'h0, 2);
    cmp("contig fetches", 2, fa.size());
    cmp("contig addr", 24'h10, fa[1]);
    $display("test frame buffer done");
    // Mono from host, bits 1,0,1,0, every depth with both colour sets
    apb(1, bsfu_pkg::OFF_SRC_ADDR, 32'h0);
    apb(1, bsfu_pkg::OFF_GEOM, 32'h0001_0004);
    apb(1, bsfu_pkg::OFF_SHARED_FG, 32'h112233);
    apb(1, bsfu_pkg::OFF_SHARED_BG, 32'h445566);
    apb(1, bsfu_pkg::OFF_SRC_FG, 32'hAABBCC);
    apb(1, bsfu_pkg::OFF_SRC_BG, 32'hDDEEF0);
    for (int s = 0; s < 2; s++) begin
      for (int d = 0; d < 3; d++) begin
        apb(1, bsfu_pkg::OFF_MONO_CTL, {4'h0, s[0], 27'h0});
        apb(1, bsfu_pkg::OFF_BLIT_CTL, {19'h0, 1'b1, 1'b0, 1'b1, 8'h0, d[1:0]});
        exp.delete();
        for (int b = 0; b < 4; b++) begin
          c = s ? (b[0] ? 24'hDDEEF0 : 24'hAABBCC) : (b[0] ? 24'h445566 : 24'h112233);
          for (int k = 0; k <= d; k++) exp.push_back(c[8*k+:8]);
        end
        go(1, 64'h0000_0000_0000_0005, 1);
      end
    end
    $display("test mono host done");
    // Host mono, two lines: byte skip, first discard, both clips, byte alignment
    apb(1, bsfu_pkg::OFF_SRC_ADDR, 32'h1);
    apb(1, bsfu_pkg::OFF_GEOM, 32'h0002_0008);
    apb(1, bsfu_pkg::OFF_MONO_CTL, 32'h0301_0102);
    apb(1, bsfu_pkg::OFF_BLIT_CTL, 32'h0000_1400);
    exp = '{8'h33, 8'h66, 8'h33, 8'h66, 8'h33, 8'h33, 8'h66, 8'h33, 8'h66, 8'h33};
    go(1, 64'h0000_0000_5400_A800, 2);
    $display("test mono clip done");
    end_sim();
  end
endmodule
`default_nettype wire
